/* File: logic/tba_params.svh */
`ifndef TBA_PARAMS_SVH
`define TBA_PARAMS_SVH

// Transfer size codes on the size pins
`define TBA_SIZE_LONG 2'h0
`define TBA_SIZE_BYTE 2'h1
`define TBA_SIZE_WORD 2'h2
`define TBA_SIZE_LINE 2'h3

// Beats in a line burst and in any other access
`define TBA_LINE_BEATS 3'h4
`define TBA_SINGLE_BEATS 3'h1

// Cycles spent decoding before chip select goes active
`define TBA_DECODE_CYCLES 2'h2

// Reset values
`define TBA_ADDR_RESET 32'h0000_0000
`define TBA_BE_NONE 4'h0

`endif

/* File: logic/tba_pkg.sv */
package tba_pkg;

    typedef enum logic [1:0] {
        TBA_ARB_RESET,
        TBA_ARB_EXTERNAL,
        TBA_ARB_IMPLICIT,
        TBA_ARB_EXPLICIT
    } tba_arb_state_t;

    typedef enum logic [2:0] {
        TBA_SLV_IDLE,
        TBA_SLV_DECODE,
        TBA_SLV_SELECT,
        TBA_SLV_ACK,
        TBA_SLV_END
    } tba_slv_state_t;

    typedef struct packed {
        tba_arb_state_t state;
        logic ts;
        logic transfer_in_progress;
        logic bd;
        logic br;
        logic drive;
        logic [31:0] addr;
        logic rw;
        logic [1:0] size;
        logic [2:0] beats;
        logic done;
    } tba_arb_regs_t;

endpackage

/* File: logic/tba_if.sv */
`timescale 1ns/1ps

interface tba_if #(
    parameter int NUM_CS = 8
);
    logic enable;
    logic ts;
    logic [31:0] addr;
    logic rw;
    logic [1:0] size;
    logic [NUM_CS-1:0] cs_n;
    logic [3:0] be_n;
    logic ta;
    logic busy;

    modport arb (output enable, output ts, output addr, output rw, output size,
                 input cs_n, input be_n, input ta, input busy);
    modport slave (input enable, input ts, input addr, input rw, input size,
                   output cs_n, output be_n, output ta, output busy);
endinterface

/* File: logic/tba_slave.sv */
`timescale 1ns/1ps
`include "tba_params.svh"

module tba_slave #(
    parameter int NUM_CS = 8,
    parameter logic [NUM_CS*8-1:0] CS_BASE = {8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h00}
) (
    input logic clock,
    input logic rst_n,
    tba_if.slave link
);
    import tba_pkg::*;

    typedef struct packed {
        tba_slv_state_t state;
        logic [31:0] addr;
        logic rw;
        logic [1:0] size;
        logic [1:0] dcnt;
        logic [2:0] beats;
        logic [NUM_CS-1:0] hit;
        logic [NUM_CS-1:0] cs;
        logic [3:0] be;
        logic ta;
    } tba_slv_regs_t;

    tba_slv_regs_t r;
    tba_slv_regs_t next_r;

    // One-hot chip select match on the top address byte
    function automatic logic [NUM_CS-1:0] cs_match(input logic [31:0] a);
        logic [NUM_CS-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_CS; i++) begin
            m[i] = (a[31:24] == CS_BASE[i*8 +: 8]);
        end
        return m;
    endfunction

    // Active-high lane mask from size and low address bits
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] m;
        unique case (sz)
            `TBA_SIZE_BYTE: m = 4'h8 >> a;
            `TBA_SIZE_WORD: m = a[1] ? 4'h3 : 4'hC;
            default: m = 4'hF;
        endcase
        return m;
    endfunction

    always_comb begin
        next_r = r;
        unique case (r.state)
            TBA_SLV_IDLE: begin
                // Only the single start pulse opens an access
                if (link.enable && link.ts) begin
                    next_r.state = TBA_SLV_DECODE;
                    next_r.addr = link.addr;
                    next_r.rw = link.rw;
                    next_r.size = link.size;
                    next_r.dcnt = `TBA_DECODE_CYCLES;
                    next_r.beats = (link.size == `TBA_SIZE_LINE) ? `TBA_LINE_BEATS : `TBA_SINGLE_BEATS;
                    next_r.hit = cs_match(link.addr);
                end
            end
            TBA_SLV_DECODE: begin
                if (r.dcnt == 2'h1) begin
                    if (|r.hit) begin
                        next_r.state = TBA_SLV_SELECT;
                        next_r.cs = r.hit;
                        next_r.be = lanes(r.size, r.addr[1:0]);
                    end else begin
                        next_r.state = TBA_SLV_IDLE;
                    end
                end else begin
                    next_r.dcnt = r.dcnt - 2'h1;
                end
            end
            TBA_SLV_SELECT: begin
                next_r.state = TBA_SLV_ACK;
                next_r.ta = 1'b1;
            end
            TBA_SLV_ACK: begin
                if (r.beats == 3'h1) begin
                    next_r.state = TBA_SLV_END;
                    next_r.ta = 1'b0;
                end else begin
                    next_r.beats = r.beats - 3'h1;
                end
            end
            TBA_SLV_END: begin
                next_r.state = TBA_SLV_IDLE;
                next_r.cs = '0;
                next_r.be = `TBA_BE_NONE;
            end
            default: next_r.state = TBA_SLV_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r <= '{state: TBA_SLV_IDLE, addr: `TBA_ADDR_RESET, be: `TBA_BE_NONE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.cs_n = ~r.cs;
    assign link.be_n = ~r.be;
    assign link.ta = r.ta;
    assign link.busy = (r.state != TBA_SLV_IDLE);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_capture_hold: assert property ((r.state != TBA_SLV_IDLE) |=> $stable(r.addr) && $stable(r.rw))
        else $error("captured address moved during access");
    a_select_time: assert property ((r.state == TBA_SLV_IDLE && link.enable && link.ts
        && |cs_match(link.addr)) |-> ##3 (|r.cs && !r.ta))
        else $error("chip select not active in fourth cycle");
    a_first_beat: assert property ((r.state == TBA_SLV_SELECT) |=> r.ta && |r.cs)
        else $error("first acknowledge missing");
    a_line_burst: assert property ((r.state == TBA_SLV_SELECT && r.size == `TBA_SIZE_LINE)
        |=> (r.ta && |r.cs)[*4] ##1 (!r.ta && |r.cs) ##1 (r.cs == '0 && r.be == 4'h0))
        else $error("line burst acknowledge pattern wrong");
    c_line_burst: cover property ((r.state == TBA_SLV_SELECT && r.size == `TBA_SIZE_LINE) ##5 (r.state == TBA_SLV_END));
    c_single: cover property ((r.state == TBA_SLV_SELECT && r.size != `TBA_SIZE_LINE) ##2 (r.state == TBA_SLV_END));

endmodule // tba_slave

/* File: logic/tba_arbiter.sv */
`timescale 1ns/1ps
`include "tba_params.svh"

module tba_arbiter #(
    parameter int NUM_CS = 8,
    parameter logic [NUM_CS*8-1:0] CS_BASE = {8'h70, 8'h60, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h00}
) (
    input logic clock,
    input logic rst_n,
    input logic req_valid,
    input logic [31:0] req_addr,
    input logic req_rw,
    input logic [1:0] req_size,
    output logic req_ready,
    output logic req_done,
    input logic bus_grant_in_n,
    output logic bus_driven_out_n,
    output logic bus_request_out_n,
    input logic transfer_start_in_n,
    output logic transfer_start_out_n,
    output logic transfer_start_oe,
    input logic [31:0] addr_in,
    output logic [31:0] addr_out,
    output logic addr_oe,
    input logic rw_in,
    output logic rw_out,
    output logic rw_oe,
    input logic [1:0] transfer_size_in,
    output logic [1:0] transfer_size_out,
    output logic transfer_size_oe,
    output logic transfer_in_progress_out_n,
    output logic transfer_in_progress_oe,
    input logic transfer_ack_in_n,
    output logic transfer_ack_out_n,
    output logic transfer_ack_oe,
    output logic [NUM_CS-1:0] chip_select_n,
    output logic [3:0] byte_enables_n
);
    import tba_pkg::*;

    tba_arb_regs_t r;
    tba_arb_regs_t next_r;
    logic grant;
    logic start;
    logic beat_ack;
    logic cycle_end;

    // Slave side answers the external master's accesses
    tba_if #(.NUM_CS(NUM_CS)) link ();

    tba_slave #(.NUM_CS(NUM_CS), .CS_BASE(CS_BASE)) u_slave (
        .clock(clock),
        .rst_n(rst_n),
        .link(link)
    );

    // Grant pin carries the external device's hold request, low means granted
    assign grant = ~bus_grant_in_n;
    assign beat_ack = r.transfer_in_progress && !transfer_ack_in_n;
    assign cycle_end = beat_ack && (r.beats == 3'h1);

    // Slave opens a new access only while the external device owns the bus; one already open runs to its end
    assign link.enable = (r.state == TBA_ARB_EXTERNAL);
    assign link.ts = !transfer_start_in_n;
    assign link.addr = addr_in;
    assign link.rw = rw_in;
    assign link.size = transfer_size_in;

    always_comb begin
        next_r = r;
        next_r.ts = 1'b0;
        next_r.done = 1'b0;
        // Request shows only while granted; a start below clears it
        next_r.br = req_valid && grant;
        start = 1'b0;
        unique case (r.state)
            TBA_ARB_RESET: begin
                next_r.bd = 1'b0;
                next_r.drive = 1'b0;
                next_r.state = grant ? TBA_ARB_IMPLICIT : TBA_ARB_EXTERNAL;
            end
            TBA_ARB_EXTERNAL: begin
                if (grant) begin
                    // Starting here takes the cycle right after grant
                    start = req_valid;
                    next_r.state = TBA_ARB_IMPLICIT;
                end
            end
            TBA_ARB_IMPLICIT: begin
                if (!grant) begin
                    next_r.state = TBA_ARB_EXTERNAL;
                end else begin
                    start = req_valid;
                end
            end
            TBA_ARB_EXPLICIT: begin
                // A started cycle ignores grant loss until its last beat
                if (r.transfer_in_progress) begin
                    if (beat_ack && !cycle_end) begin
                        next_r.beats = r.beats - 3'h1;
                    end
                    if (cycle_end) begin
                        next_r.transfer_in_progress = 1'b0;
                        next_r.done = 1'b1;
                        if (!grant) begin
                            next_r.state = TBA_ARB_EXTERNAL;
                            next_r.bd = 1'b0;
                            next_r.drive = 1'b0;
                        end else begin
                            start = req_valid;
                        end
                    end
                end else if (!grant) begin
                    next_r.state = TBA_ARB_EXTERNAL;
                    next_r.bd = 1'b0;
                    next_r.drive = 1'b0;
                end else begin
                    start = req_valid;
                end
            end
        endcase
        if (start) begin
            next_r.state = TBA_ARB_EXPLICIT;
            next_r.ts = 1'b1;
            next_r.transfer_in_progress = 1'b1;
            next_r.bd = 1'b1;
            next_r.drive = 1'b1;
            next_r.br = 1'b0;
            next_r.addr = req_addr;
            next_r.rw = req_rw;
            next_r.size = req_size;
            next_r.beats = (req_size == `TBA_SIZE_LINE) ? `TBA_LINE_BEATS : `TBA_SINGLE_BEATS;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r <= '{state: TBA_ARB_RESET, addr: `TBA_ADDR_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Ready is combinational, so the edge that samples it high takes the request
    assign req_ready = start;
    assign req_done = r.done;
    assign bus_driven_out_n = ~r.bd;
    assign bus_request_out_n = ~r.br;
    assign transfer_start_out_n = ~r.ts;
    assign transfer_start_oe = r.drive;
    assign addr_out = r.addr;
    assign addr_oe = r.drive;
    assign rw_out = r.rw;
    assign rw_oe = r.drive;
    assign transfer_size_out = r.size;
    assign transfer_size_oe = r.drive;
    assign transfer_in_progress_out_n = ~r.transfer_in_progress;
    assign transfer_in_progress_oe = r.drive;
    assign transfer_ack_out_n = ~link.ta;
    assign transfer_ack_oe = link.busy;
    assign chip_select_n = link.cs_n;
    assign byte_enables_n = link.be_n;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_hold_quiet: assert property ((r.state == TBA_ARB_EXTERNAL && !grant) |=> !r.bd && !r.br && !r.drive)
        else $error("bus driven or request while held off");
    a_keep_cycle: assert property ((r.transfer_in_progress && !grant && !cycle_end) |=> r.bd && r.drive)
        else $error("bus released before cycle end");
    a_end_release: assert property ((cycle_end && !grant)
        |=> (!r.bd && !r.drive && r.state == TBA_ARB_EXTERNAL))
        else $error("bus not released after final transfer");
    a_start_pulse: assert property (start |=> (r.ts && r.bd && r.drive) ##1 (!r.ts && r.bd))
        else $error("start pulse or bus driven wrong");
    a_implicit_idle: assert property ((r.state == TBA_ARB_IMPLICIT) |-> !r.bd && !r.drive)
        else $error("bus driven in implicit mastership");
    a_grant_start: assert property ((r.state == TBA_ARB_IMPLICIT && grant && req_valid) |=> r.ts)
        else $error("pending request not started at once");
    a_explicit_hold: assert property ((r.state == TBA_ARB_EXPLICIT && grant) |=> r.bd)
        else $error("bus driven dropped while granted");
    a_reset_quiet: assert property ((r.state == TBA_ARB_RESET) |-> !r.bd && !r.br && !r.drive)
        else $error("outputs active in reset state");
    a_held_no_request: assert property (!grant |=> !r.br)
        else $error("bus request raised without grant");
    a_first_cycle: assert property ((r.state == TBA_ARB_EXTERNAL && grant && req_valid)
        |=> r.ts && r.bd && r.drive)
        else $error("start not in cycle after grant");
    a_idle_release: assert property ((r.state == TBA_ARB_EXPLICIT && !r.transfer_in_progress && !grant)
        |=> !r.bd && !r.drive)
        else $error("idle explicit master kept bus after grant loss");
    a_busy_no_take: assert property ((r.transfer_in_progress && !cycle_end) |-> !req_ready)
        else $error("request taken inside a running cycle");
    a_reset_exit: assert property ((r.state == TBA_ARB_RESET) |=> (r.state != TBA_ARB_RESET))
        else $error("reset state held after release");
    a_start_addr: assert property (start |=> (r.addr == $past(req_addr) && r.rw == $past(req_rw)))
        else $error("started cycle shows wrong address");

    c_implicit_to_explicit: cover property ((r.state == TBA_ARB_IMPLICIT) ##1 (r.state == TBA_ARB_EXPLICIT));
    c_lost_grant: cover property ((r.transfer_in_progress && !grant) ##[1:20] (r.state == TBA_ARB_EXTERNAL));
    c_grant_take: cover property ((r.state == TBA_ARB_EXTERNAL) && start);

endmodule // tba_arbiter

/* File: sim/tba_ext_device.sv */
`timescale 1ns/1ps

module tba_ext_device (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic go,
    input wire logic [31:0] go_addr,
    input wire logic go_rw,
    input wire logic [1:0] go_size,
    input wire logic [1:0] ack_wait,
    input wire logic bus_driven_out_n,
    input wire logic transfer_start_out_n,
    input wire logic [1:0] transfer_size_out,
    output logic bus_grant_in_n,
    output logic transfer_start_in_n,
    output logic [31:0] addr_in,
    output logic rw_in,
    output logic [1:0] transfer_size_in,
    output logic transfer_ack_in_n
);
    logic [3:0] own;
    logic [2:0] pend;
    logic [1:0] dly;

    // Released lines toggle so a late capture sees garbage
    always @(posedge clock) begin
        transfer_start_in_n <= 1'b1;
        transfer_ack_in_n <= 1'b1;
        addr_in <= ~addr_in;
        rw_in <= ~rw_in;
        transfer_size_in <= ~transfer_size_in;
        if (!rst_n) begin
            bus_grant_in_n <= 1'b1;
            own <= 4'h0;
            pend <= 3'h0;
            dly <= 2'h0;
            addr_in <= 32'h0;
            rw_in <= 1'b0;
            transfer_size_in <= 2'h0;
        end else begin
            bus_grant_in_n <= hold || own != 4'h0;
            if (own != 4'h0) own <= own - 4'h1;
            if (go && bus_grant_in_n && bus_driven_out_n && own == 4'h0) begin
                transfer_start_in_n <= 1'b0;
                addr_in <= go_addr;
                rw_in <= go_rw;
                transfer_size_in <= go_size;
                own <= 4'hC;
            end
            // Memory side acknowledges the arbiter's cycles, started by its transfer_start_out_n
            if (pend != 3'h0) begin
                if (dly != 2'h0) dly <= dly - 2'h1;
                else transfer_ack_in_n <= 1'b0;
                if (dly == 2'h0) pend <= pend - 3'h1;
            end
            if (!transfer_start_out_n) begin
                pend <= (transfer_size_out == 2'h3) ? 3'h4 : 3'h1;
                dly <= ack_wait;
            end
        end
    end
endmodule // tba_ext_device

/* File: sim/test_tba_arbiter.sv */
`timescale 1ns/1ps

module test_tba_arbiter;
    logic clock = 1'b0;
    logic rst_n, req_valid, req_rw, req_ready, req_done, bus_grant_in_n, bus_driven_out_n;
    logic bus_request_out_n, transfer_start_in_n, transfer_start_out_n, transfer_start_oe;
    logic rw_in, rw_out, rw_oe, addr_oe, transfer_size_oe, transfer_in_progress_out_n;
    logic transfer_in_progress_oe, transfer_ack_in_n, transfer_ack_out_n, transfer_ack_oe;
    logic [31:0] req_addr, addr_in, addr_out, go_addr, r;
    logic [1:0] req_size, transfer_size_in, transfer_size_out, go_size, ack_wait;
    logic [7:0] chip_select_n;
    logic [3:0] byte_enables_n;
    logic hold, go, go_rw;
    int bad_count, total_checks, cycles, seed;

    tba_arbiter dut (
        .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_addr(req_addr), .req_rw(req_rw),
        .req_size(req_size), .req_ready(req_ready), .req_done(req_done), .bus_grant_in_n(bus_grant_in_n),
        .bus_driven_out_n(bus_driven_out_n), .bus_request_out_n(bus_request_out_n),
        .transfer_start_in_n(transfer_start_in_n), .transfer_start_out_n(transfer_start_out_n),
        .transfer_start_oe(transfer_start_oe), .addr_in(addr_in), .addr_out(addr_out), .addr_oe(addr_oe),
        .rw_in(rw_in), .rw_out(rw_out), .rw_oe(rw_oe), .transfer_size_in(transfer_size_in),
        .transfer_size_out(transfer_size_out), .transfer_size_oe(transfer_size_oe),
        .transfer_in_progress_out_n(transfer_in_progress_out_n), .transfer_in_progress_oe(transfer_in_progress_oe),
        .transfer_ack_in_n(transfer_ack_in_n), .transfer_ack_out_n(transfer_ack_out_n),
        .transfer_ack_oe(transfer_ack_oe), .chip_select_n(chip_select_n), .byte_enables_n(byte_enables_n)
    );
    tba_ext_device partner (
        .clock(clock), .rst_n(rst_n), .hold(hold), .go(go), .go_addr(go_addr), .go_rw(go_rw), .go_size(go_size),
        .ack_wait(ack_wait), .bus_driven_out_n(bus_driven_out_n), .transfer_start_out_n(transfer_start_out_n),
        .transfer_size_out(transfer_size_out), .bus_grant_in_n(bus_grant_in_n),
        .transfer_start_in_n(transfer_start_in_n), .addr_in(addr_in), .rw_in(rw_in),
        .transfer_size_in(transfer_size_in), .transfer_ack_in_n(transfer_ack_in_n)
    );

    always #2 clock = ~clock;

    task wrap_up;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            wrap_up;
        end
    end

    task chk(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    function automatic logic [7:0] exp_cs(input logic [31:0] a);
        exp_cs = 8'hFF;
        if (!a[31] && a[27:24] == 4'h0) exp_cs[a[30:28]] = 1'b0;
    endfunction

    function automatic logic [3:0] exp_be(input logic [31:0] a, input logic [1:0] s);
        case (s)
            2'h1: exp_be = ~(4'h8 >> a[1:0]);
            2'h2: exp_be = a[1] ? 4'hC : 4'h3;
            default: exp_be = 4'h0;
        endcase
    endfunction

    task ext_access(input logic [31:0] a, input logic [1:0] s, input logic rw);
        logic hit, cs_on, ack_on;
        int nb;
        hit = exp_cs(a) != 8'hFF;
        nb = (s == 2'h3) ? 4 : 1;
        hold = 1'b1;
        repeat (4) @(negedge clock);
        go = 1'b1;
        go_addr = a;
        go_size = s;
        go_rw = rw;
        @(negedge clock);
        go = 1'b0;
        for (int k = 0; k < 12; k++) begin
            cs_on = hit && k >= 3 && k <= 4 + nb;
            ack_on = hit && k >= 4 && k <= 3 + nb;
            chk(chip_select_n === (cs_on ? exp_cs(a) : 8'hFF), "select");
            chk(byte_enables_n === (cs_on ? exp_be(a, s) : 4'hF), "lanes");
            chk((transfer_ack_oe & ~transfer_ack_out_n) === ack_on, "ack");
            chk(bus_driven_out_n === 1'b1 && bus_request_out_n === 1'b1, "held");
            @(negedge clock);
        end
    endtask

    task own_access(input logic [31:0] a, input logic [1:0] s, input logic rw, input logic [1:0] w,
                    input logic drop);
        int n, held;
        held = hold;
        @(negedge clock);
        req_valid = 1'b1;
        req_addr = a;
        req_size = s;
        req_rw = rw;
        ack_wait = w;
        repeat (3 * held) begin
            @(negedge clock);
            chk(bus_request_out_n === 1'b1 && bus_driven_out_n === 1'b1 && req_ready === 1'b0, "early");
        end
        hold = 1'b0;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clock);
            #1;
            n++;
        end
        chk(n == held, "take");
        @(negedge clock);
        req_valid = 1'b0;
        chk(transfer_start_out_n === 1'b0 && transfer_start_oe === 1'b1 && bus_driven_out_n === 1'b0, "start");
        chk(addr_out === a && addr_oe === 1'b1 && rw_out === rw && transfer_size_out === s, "addr");
        chk(transfer_size_oe === 1'b1 && rw_oe === 1'b1, "attr");
        chk(transfer_in_progress_out_n === 1'b0 && transfer_in_progress_oe === 1'b1, "tip on");
        hold = drop;
        n = 0;
        while (req_done !== 1'b1 && n < 30) begin
            chk(bus_driven_out_n === 1'b0 && addr_oe === 1'b1, "let go");
            chk(n == 0 || transfer_start_out_n === 1'b1, "pulse");
            @(negedge clock);
            n++;
        end
        chk(n == 2 + w + ((s == 2'h3) ? 4 : 1), "beats");
        chk(transfer_in_progress_out_n === 1'b1, "tip");
        if (drop) chk(transfer_size_oe === 1'b0 && transfer_in_progress_oe === 1'b0, "float");
        if (drop) chk(bus_driven_out_n === 1'b1 && addr_oe === 1'b0 && rw_oe === 1'b0, "release");
        else chk(bus_driven_out_n === 1'b0 && addr_oe === 1'b1, "kept");
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_addr = 32'h0;
        req_rw = 1'b0;
        req_size = 2'h0;
        hold = 1'b1;
        go = 1'b0;
        go_addr = 32'h0;
        go_rw = 1'b0;
        go_size = 2'h0;
        ack_wait = 2'h0;
        seed = 32'h13A863F0;
        repeat (16) @(negedge clock);
        chk(bus_driven_out_n === 1'b1 && bus_request_out_n === 1'b1 && addr_oe === 1'b0, "rst");
        chk(chip_select_n === 8'hFF && transfer_ack_oe === 1'b0 && transfer_start_oe === 1'b0, "rst2");
        chk(rw_oe === 1'b0 && transfer_size_oe === 1'b0 && transfer_in_progress_oe === 1'b0, "rst3");
        rst_n = 1'b1;
        ext_access(32'h1000_0004, 2'h3, 1'b1);
        ext_access(32'h7000_0003, 2'h1, 1'b0);
        ext_access(32'h2000_0002, 2'h2, 1'b1);
        ext_access(32'h3000_0000, 2'h0, 1'b0);
        ext_access(32'h9000_0000, 2'h3, 1'b1);
        own_access(32'h1234_5670, 2'h3, 1'b1, 2'h0, 1'b0);
        own_access(32'h0000_0010, 2'h0, 1'b0, 2'h1, 1'b0);
        own_access(32'h4000_0008, 2'h3, 1'b0, 2'h2, 1'b1);
        hold = 1'b0;
        repeat (4) @(negedge clock);
        chk(bus_driven_out_n === 1'b1 && addr_oe === 1'b0 && bus_request_out_n === 1'b1, "implicit");
        own_access(32'h5000_0001, 2'h1, 1'b1, 2'h0, 1'b0);
        repeat (24) begin
            r = $random(seed);
            go_addr = $random(seed);
            if (r[0]) ext_access({go_addr[31] & go_addr[30], go_addr[30:0]}, r[2:1], r[3]);
            else own_access(go_addr, r[2:1], r[3], r[5:4], r[6]);
        end
        wrap_up;
    end
endmodule // test_tba_arbiter
